// ---- design/sdlp_core.sv ----
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module sdlp_core (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Command sequencer side
  input  wire logic                 access_req,
  output logic                      access_grant,
  input  wire logic                 init_req,
  input  wire logic                 refresh_error,
  output logic                      refresh_start,
  output logic [1:0]                memory_device_type,
  // Memory side
  input  wire logic                 link_clk,
  output logic                      memory_clock_out,
  output logic                      memory_clock_enable_pin,
  output logic [2:0]                mem_cmd,
  output logic                      mem_cmd_valid,
  output logic [7:0]                mem_ext_mode,
  output logic                      irq
);
  import sdlp_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [13:0] lpc_reg;
  logic [3:0]  exit_delay_reg;
  logic [TMR_COUNT_W-1:0] tmr_count_reg, tmr_cnt_reg;
  logic        tmr_written_reg, refresh_start_reg;
  logic        rferr_mask_reg, rferr_status_reg;
  logic [1:0]  dev_type_reg;
  sdlp_state_t state_reg, state_next;
  logic [7:0]  idle_cnt_reg;
  logic [3:0]  exit_cnt_reg;
  logic [1:0]  sleep_kind_reg;
  logic        cke_reg, clk_run_reg, clk_out_reg;
  logic [2:0]  cmd_reg;
  logic        cmd_valid_reg;
  logic [7:0]  ext_mode_reg;
  logic        lclk_meta_reg, lclk_sync_reg;

  // Fold byte strobes into a base word; the decode passes zero, not the stored value
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] merged;
    merged = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return merged;
  endfunction : strb_merge

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Write fires once both halves are held; response follows next edge
  wire        wr_fire    = aw_held_reg && w_held_reg && !bvalid_reg;
  wire        rd_fire    = s_axi_arvalid && !rvalid_reg;
  wire        wr_lpc     = wr_fire && (awaddr_reg == ADDR_LOW_POWER_CTRL);
  wire        wr_tcfg    = wr_fire && (awaddr_reg == ADDR_TIMING_CONFIG);
  wire        wr_tmr     = wr_fire && (awaddr_reg == ADDR_REFRESH_TIMER);
  wire        wr_ier     = wr_fire && (awaddr_reg == ADDR_IRQ_ENABLE);
  wire        wr_idr     = wr_fire && (awaddr_reg == ADDR_IRQ_DISABLE);
  wire        wr_mdr     = wr_fire && (awaddr_reg == ADDR_MEM_TYPE_SEL);
  wire        wr_hit     = wr_lpc | wr_tcfg | wr_tmr | wr_ier | wr_idr | wr_mdr
                           | (wr_fire && (awaddr_reg == ADDR_IRQ_MASK))
                           | (wr_fire && (awaddr_reg == ADDR_IRQ_STATUS));
  wire [31:0] wmerged    = strb_merge(32'h0, wdata_reg, wstrb_reg);
  wire        rferr_wr_one = wstrb_reg[0] && wdata_reg[IRQ_RFERR_BIT];
  // Timer count needs both low byte lanes, or a partial write could reload junk
  wire        wr_tmr_ok  = wr_tmr && wstrb_reg[0] && wstrb_reg[1];
  wire        rd_status  = rd_fire && (s_axi_araddr == ADDR_IRQ_STATUS);

  // Read mux; write-only registers read as zero
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ADDR_REFRESH_TIMER:  rd_word = {20'h0, tmr_count_reg};
      ADDR_TIMING_CONFIG:  rd_word = {exit_delay_reg, 28'h0};
      ADDR_LOW_POWER_CTRL: rd_word = {18'h0, lpc_reg};
      ADDR_IRQ_ENABLE:     rd_word = 32'h0;
      ADDR_IRQ_DISABLE:    rd_word = 32'h0;
      ADDR_IRQ_MASK:       rd_word = {31'h0, rferr_mask_reg};
      ADDR_IRQ_STATUS:     rd_word = {31'h0, rferr_status_reg};
      ADDR_MEM_TYPE_SEL:   rd_word = {30'h0, dev_type_reg};
      default:             rd_hit  = 1'b0;
    endcase
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= 32'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[31:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpc_reg         <= 14'h0;
      exit_delay_reg  <= EXIT_DELAY_RST;
      tmr_count_reg   <= '0;
      tmr_written_reg <= 1'b0;
      dev_type_reg    <= DEV_SDRAM;
    end else begin
      if (wr_lpc) lpc_reg <= wmerged[13:0] & 14'h3F73;
      if (wr_tcfg && wstrb_reg[3]) exit_delay_reg <= wdata_reg[TCFG_EXIT_LSB +: 4];
      if (wr_tmr_ok) begin
        tmr_count_reg   <= wdata_reg[TMR_COUNT_W-1:0];
        tmr_written_reg <= 1'b1;
      end
      if (wr_mdr && wstrb_reg[0]) dev_type_reg <= wdata_reg[1:0];
    end
  end

  wire [1:0] lp_cfg     = lpc_reg[LPC_CFG_LSB +: 2];
  wire [1:0] lp_timeout = lpc_reg[LPC_TIMEOUT_LSB +: 2];
  assign memory_device_type = dev_type_reg;

  // ----------------------------------------------------------------
  // Refresh-error interrupt
  // ----------------------------------------------------------------
  // Flag set beats the clear-on-read so a coinciding error is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rferr_mask_reg   <= 1'b0;
      rferr_status_reg <= 1'b0;
    end else begin
      if (wr_ier && rferr_wr_one) rferr_mask_reg <= 1'b1;
      else if (wr_idr && rferr_wr_one) rferr_mask_reg <= 1'b0;
      if (refresh_error) rferr_status_reg <= 1'b1;
      else if (rd_status) rferr_status_reg <= 1'b0;
    end
  end

  assign irq = rferr_status_reg && rferr_mask_reg;

  // ----------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------
  // Silent until software programs the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_cnt_reg       <= '0;
      refresh_start_reg <= 1'b0;
    end else begin
      refresh_start_reg <= 1'b0;
      if (!tmr_written_reg || wr_tmr_ok) begin
        tmr_cnt_reg <= wr_tmr_ok ? wdata_reg[TMR_COUNT_W-1:0] : '0;
      end else if (tmr_cnt_reg == '0) begin
        tmr_cnt_reg       <= tmr_count_reg;
        refresh_start_reg <= 1'b1;
      end else begin
        tmr_cnt_reg <= tmr_cnt_reg - 1'b1;
      end
    end
  end
  assign refresh_start = refresh_start_reg;

  // ----------------------------------------------------------------
  // Low-power sequencing
  // ----------------------------------------------------------------
  // Reserved timeout 11 never enters low power, as the safe reading
  wire [7:0] idle_limit = (lp_timeout == TO_64)  ? IDLE_CYC_64 :
                          (lp_timeout == TO_128) ? IDLE_CYC_128 : 8'h0;
  wire deep_ok     = (lp_cfg != LP_DEEP) || (dev_type_reg == DEV_LP);
  wire lp_allowed  = (lp_cfg != LP_OFF) && (lp_timeout != 2'h3) && deep_ok;
  wire idle_done   = (idle_cnt_reg >= idle_limit);
  wire wake_done   = (exit_cnt_reg >= exit_delay_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_AWAKE:     if (access_req) state_next = ST_BUSY;
                    else if (lp_allowed) state_next = ST_IDLE_WAIT;
      ST_BUSY:      if (!access_req) state_next = lp_allowed ? ST_IDLE_WAIT : ST_AWAKE;
      ST_IDLE_WAIT: if (access_req) state_next = ST_BUSY;
                    else if (!lp_allowed) state_next = ST_AWAKE;
                    else if (idle_done) state_next = ST_ASLEEP;
      ST_ASLEEP:    if (access_req) state_next = ST_WAKING;
      ST_WAKING:    if (wake_done) state_next = ST_BUSY;
      default:      state_next = ST_AWAKE;
    endcase
  end

  // Grant only once the memory is awake and the exit delay has run
  assign access_grant = (state_reg == ST_BUSY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_AWAKE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Idle and exit-delay counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_reg <= 8'h0;
      exit_cnt_reg <= 4'h0;
    end else begin
      idle_cnt_reg <= (state_reg == ST_IDLE_WAIT && !idle_done) ? idle_cnt_reg + 8'h1
                    : (state_reg == ST_IDLE_WAIT) ? idle_cnt_reg : 8'h0;
      exit_cnt_reg <= (state_reg == ST_WAKING && !wake_done) ? exit_cnt_reg + 4'h1
                    : 4'h0;
    end
  end

  // Command issue, clock-enable and clock gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_reg        <= 1'b1;
      clk_run_reg    <= 1'b1;
      cmd_reg        <= 3'h0;
      cmd_valid_reg  <= 1'b0;
      sleep_kind_reg <= LP_OFF;
      ext_mode_reg   <= 8'h0;
    end else begin
      cmd_valid_reg <= 1'b0;
      if (state_reg == ST_IDLE_WAIT && state_next == ST_ASLEEP) begin
        sleep_kind_reg <= lp_cfg;
        cmd_valid_reg  <= 1'b1;
        cke_reg        <= 1'b0;
        case (lp_cfg)
          LP_SELF: begin
            cmd_reg     <= CMD_SELF_REFRESH;
            clk_run_reg <= 1'b0;
          end
          LP_PDN:  cmd_reg <= CMD_POWER_DOWN;
          default: cmd_reg <= CMD_DEEP_PDN;
        endcase
      end else if (state_reg == ST_ASLEEP && access_req) begin
        cke_reg       <= 1'b1;
        clk_run_reg   <= 1'b1;
        cmd_reg       <= CMD_WAKE;
        cmd_valid_reg <= 1'b1;
      end else if (init_req && dev_type_reg == DEV_LP) begin
        cmd_reg       <= CMD_EXT_MODE;
        cmd_valid_reg <= 1'b1;
        ext_mode_reg  <= {lpc_reg[LPC_DRIVE_LSB +: 2],
                          lpc_reg[LPC_TEMP_LSB +: 2],
                          1'b0, lpc_reg[LPC_ARRAY_LSB +: 3]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory clock regeneration
  // ----------------------------------------------------------------
  // Reference is resampled; the output is stopped low in self-refresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lclk_meta_reg <= 1'b0;
      lclk_sync_reg <= 1'b0;
      clk_out_reg   <= 1'b0;
    end else begin
      lclk_meta_reg <= link_clk;
      lclk_sync_reg <= lclk_meta_reg;
      clk_out_reg   <= lclk_sync_reg && clk_run_reg;
    end
  end

  assign memory_clock_out        = clk_out_reg;
  assign memory_clock_enable_pin = cke_reg;
  assign mem_cmd                 = cmd_reg;
  assign mem_cmd_valid           = cmd_valid_reg;
  assign mem_ext_mode            = ext_mode_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  no_lp_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lp_cfg == LP_OFF) |=> !(mem_cmd_valid && (mem_cmd == CMD_SELF_REFRESH
      || mem_cmd == CMD_POWER_DOWN || mem_cmd == CMD_DEEP_PDN)))
    else $error("low-power command issued while disabled");

  exit_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_ASLEEP && access_req) |=> !access_grant [*1] ##0
      (exit_cnt_reg == 4'h0))
    else $error("grant before exit delay");

  self_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_ASLEEP && sleep_kind_reg == LP_SELF) |-> !cke_reg && !clk_run_reg)
    else $error("self-refresh with clock or enable running");

  pdn_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE_WAIT && state_next == ST_ASLEEP && lp_cfg == LP_PDN)
      |=> mem_cmd_valid && mem_cmd == CMD_POWER_DOWN && !memory_clock_enable_pin)
    else $error("power-down entry wrong");

  deep_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_cmd_valid && mem_cmd == CMD_DEEP_PDN) |-> $past(dev_type_reg) == DEV_LP)
    else $error("deep power-down on standard part");

  idle_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE_WAIT && lp_timeout == TO_64 && idle_cnt_reg < IDLE_CYC_64)
      |-> state_next != ST_ASLEEP)
    else $error("early low-power entry");

  irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (refresh_error && rferr_mask_reg && !(wr_idr && rferr_wr_one)) |=> irq)
    else $error("interrupt missing after error");

  rd_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_status && !refresh_error) |=> !rferr_status_reg ##1
      rdata_reg[0] == $past(rferr_status_reg, 2))
    else $error("status read did not clear");

  enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ier && rferr_wr_one) |=> rferr_mask_reg)
    else $error("enable write ignored");

  disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_idr && rferr_wr_one && !wr_ier) |=> !rferr_mask_reg)
    else $error("disable write ignored");

  no_refresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !tmr_written_reg |=> !refresh_start_reg)
    else $error("refresh before timer programmed");

endmodule : sdlp_core

// ---- design/sdlp_pkg.sv ----
package sdlp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_REFRESH_TIMER  = 32'hFFFFEA04;
  localparam logic [31:0] ADDR_TIMING_CONFIG  = 32'hFFFFEA08;
  localparam logic [31:0] ADDR_LOW_POWER_CTRL = 32'hFFFFEA10;
  localparam logic [31:0] ADDR_IRQ_ENABLE     = 32'hFFFFEA14;
  localparam logic [31:0] ADDR_IRQ_DISABLE    = 32'hFFFFEA18;
  localparam logic [31:0] ADDR_IRQ_MASK       = 32'hFFFFEA1C;
  localparam logic [31:0] ADDR_IRQ_STATUS     = 32'hFFFFEA20;
  localparam logic [31:0] ADDR_MEM_TYPE_SEL   = 32'hFFFFEA24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LPC_CFG_LSB     = 0;
  localparam int LPC_ARRAY_LSB   = 4;
  localparam int LPC_TEMP_LSB    = 8;
  localparam int LPC_DRIVE_LSB   = 10;
  localparam int LPC_TIMEOUT_LSB = 12;
  localparam int TCFG_EXIT_LSB   = 28;
  localparam int TMR_COUNT_W     = 12;
  localparam int IRQ_RFERR_BIT   = 0;
  localparam logic [3:0]  EXIT_DELAY_RST = 4'h8;
  localparam logic [1:0]  LP_OFF  = 2'h0;
  localparam logic [1:0]  LP_SELF = 2'h1;
  localparam logic [1:0]  LP_PDN  = 2'h2;
  localparam logic [1:0]  LP_DEEP = 2'h3;
  localparam logic [1:0]  TO_NONE = 2'h0;
  localparam logic [1:0]  TO_64   = 2'h1;
  localparam logic [1:0]  TO_128  = 2'h2;
  localparam logic [1:0]  DEV_SDRAM = 2'h0;
  localparam logic [1:0]  DEV_LP    = 2'h1;

  // ----------------------------------------------------------------
  // Timing counts and memory commands
  // ----------------------------------------------------------------
  localparam logic [7:0] IDLE_CYC_64  = 8'h40;
  localparam logic [7:0] IDLE_CYC_128 = 8'h80;
  localparam logic [2:0] CMD_SELF_REFRESH = 3'h1;
  localparam logic [2:0] CMD_POWER_DOWN   = 3'h2;
  localparam logic [2:0] CMD_DEEP_PDN     = 3'h3;
  localparam logic [2:0] CMD_WAKE         = 3'h4;
  localparam logic [2:0] CMD_EXT_MODE     = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ST_AWAKE, ST_BUSY, ST_IDLE_WAIT, ST_ASLEEP, ST_WAKING
  } sdlp_state_t;

endpackage : sdlp_pkg

// ---- dv/sdlp_mem_model.sv ----
`timescale 1ns/100ps
// Memory device: supplies the link clock and keeps the last command it saw
module sdlp_mem_model (
  input  wire logic       aclk,
  input  wire logic [2:0] mem_cmd,
  input  wire logic       mem_cmd_valid,
  input  wire logic [7:0] mem_ext_mode,
  output logic            link_clk,
  output logic [2:0]      last_cmd,
  output logic [7:0]      last_ext
);
  // Free-running 64 ns reference, phase skewed against aclk
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #32 link_clk = ~link_clk;
  end
  // Latch each qualified command
  always_ff @(posedge aclk) begin
    if (mem_cmd_valid) begin
      last_cmd <= mem_cmd;
      last_ext <= mem_ext_mode;
    end
  end
endmodule : sdlp_mem_model

// ---- dv/test_sdlp_core.sv ----
`timescale 1ns/100ps
module test_sdlp_core;
  import sdlp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic access_req = 1'b0, init_req = 1'b0, refresh_error = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic access_grant, refresh_start, link_clk, memory_clock_out, memory_clock_enable_pin;
  logic mem_cmd_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, memory_device_type, rs;
  logic [2:0]  mem_cmd, last_cmd, c;
  logic [7:0]  mem_ext_mode, last_ext;
  int n_fail = 0, tests_run = 0, k, i;
  sdlp_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .access_req, .access_grant, .init_req, .refresh_error, .refresh_start,
    .memory_device_type, .link_clk, .memory_clock_out, .memory_clock_enable_pin, .mem_cmd,
    .mem_cmd_valid, .mem_ext_mode, .irq);
  sdlp_mem_model mem (.aclk, .mem_cmd, .mem_cmd_valid, .mem_ext_mode, .link_clk, .last_cmd,
    .last_ext);
  always #2 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Reporting and bus helpers
  // ----------------------------------------------------------------
  task end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tmo;
    chk("wait_bound", 0, 1);
    end_sim();
  endtask : tmo
  // Ready and valid are read at the falling edge, so the release after the
  // rising edge never races the slave's combinational ready
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    logic [1:0] wb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int j = 0; j < 64; j++) begin
      @(negedge aclk);
      ra = s_axi_awvalid & s_axi_awready;
      rw = s_axi_wvalid & s_axi_wready;
      rb = s_axi_bvalid;
      wb = s_axi_bresp;
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rb) begin
        s_axi_bready <= 1'b0;
        chk("bresp", wb, RESP_OKAY);
        return;
      end
    end
    tmo();
  endtask : wr
  task rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ra, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int j = 0; j < 64; j++) begin
      @(negedge aclk);
      ra = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ra) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : rdr
  // Count falling edges until a memory command; c stays 0 if none came
  task wcmd(input int lim);
    c = 3'h0;
    for (k = 0; k < lim; k++) begin
      @(negedge aclk);
      if (mem_cmd_valid) begin
        c = mem_cmd;
        return;
      end
    end
  endtask : wcmd
  task pulse_err;
    @(posedge aclk) refresh_error <= 1'b1;
    @(posedge aclk) refresh_error <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_err
  task set_req(input logic v);
    @(posedge aclk) access_req <= v;
  endtask : set_req
  task wake;
    set_req(1'b1);
    for (k = 0; k < 300; k++) begin
      @(negedge aclk);
      if (access_grant === 1'b1) return;
    end
    tmo();
  endtask : wake
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_refresh;
    set_req(1'b1);
    repeat (20) @(posedge aclk);
    set_req(1'b0);
    k = 0;
    repeat (200) @(negedge aclk) k += refresh_start + mem_cmd_valid;
    chk("idle_cmds", k, 0);
    wr(ADDR_REFRESH_TIMER, 32'h20);
    for (i = 0; i < 300 && refresh_start !== 1'b1; i++) @(negedge aclk);
    chk("refresh", refresh_start, 1);
  endtask : t_refresh
  task t_irq;
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    rdr(ADDR_IRQ_MASK, rd, rs);
    chk("mask_on", rd, 1);
    pulse_err();
    chk("irq_on", irq, 1);
    rdr(ADDR_IRQ_STATUS, rd, rs);
    chk("status_set", rd, 1);
    rdr(ADDR_IRQ_STATUS, rd, rs);
    chk("status_clr", rd, 0);
    chk("irq_off", irq, 0);
    wr(ADDR_IRQ_DISABLE, 32'h0);
    rdr(ADDR_IRQ_MASK, rd, rs);
    chk("mask_kept", rd, 1);
    wr(ADDR_IRQ_DISABLE, 32'h1);
    rdr(ADDR_IRQ_MASK, rd, rs);
    chk("mask_off", rd, 0);
    pulse_err();
    chk("irq_masked", irq, 0);
    rdr(ADDR_IRQ_STATUS, rd, rs);
    chk("status_masked", rd, 1);
    rdr(32'hFFFFEA30, rd, rs);
    chk("unmapped", rs, RESP_DECERR);
    wr(ADDR_MEM_TYPE_SEL, 32'h1);
    rdr(ADDR_MEM_TYPE_SEL, rd, rs);
    chk("type_reg", rd, 1);
    chk("type_out", memory_device_type, DEV_LP);
  endtask : t_irq
  task t_init;
    wr(ADDR_LOW_POWER_CTRL, 32'h650);
    @(posedge aclk) init_req <= 1'b1;
    @(posedge aclk) init_req <= 1'b0;
    wcmd(50);
    chk("ext_cmd", c, CMD_EXT_MODE);
    chk("ext_val", mem_ext_mode, 32'h65);
    @(negedge aclk);
    chk("ext_model", last_ext, 32'h65);
  endtask : t_init
  task t_self;
    k = 0;
    repeat (40) @(negedge aclk) k += memory_clock_out;
    chk("clk_running", k >= 12 && k <= 28, 1);
    wr(ADDR_TIMING_CONFIG, 32'hF0000000);
    wr(ADDR_LOW_POWER_CTRL, 32'h1);
    wcmd(8);
    chk("self_cmd", c, CMD_SELF_REFRESH);
    k = 0;
    repeat (40) @(negedge aclk) k += memory_clock_out + memory_clock_enable_pin;
    chk("clk_stopped", k, 0);
    set_req(1'b1);
    i = 0;
    for (k = 0; k < 300 && access_grant !== 1'b1; k++) @(negedge aclk) i += memory_clock_enable_pin;
    chk("exit_delay", i >= 15 && i <= 18, 1);
    chk("wake_cmd", last_cmd, CMD_WAKE);
    set_req(1'b0);
    wcmd(8);
    chk("self_again", c, CMD_SELF_REFRESH);
  endtask : t_self
  // Power-down with the 64 and 128 timeouts, then the reserved one, then deep power-down with no timeout
  task t_pdn;
    logic [31:0] cfg [4] = '{32'h1002, 32'h2002, 32'h3002, 32'h0003};
    logic [2:0] exp [4] = '{CMD_POWER_DOWN, CMD_POWER_DOWN, 3'h0, CMD_DEEP_PDN};
    int lo [4] = '{63, 127, 400, 0};
    for (int j = 0; j < 4; j++) begin
      wake();
      wr(ADDR_LOW_POWER_CTRL, cfg[j]);
      set_req(1'b0);
      wcmd(400);
      chk("lp_cmd", c, exp[j]);
      chk("lp_delay", k >= lo[j] && k <= lo[j] + 4, 1);
      if (j < 2) chk("cke_low", memory_clock_enable_pin, 0);
    end
    // Deep power-down must be refused once the part is standard SDRAM
    wr(ADDR_MEM_TYPE_SEL, 32'h0);
    wake();
    set_req(1'b0);
    wcmd(50);
    chk("deep_sdram", c, 3'h0);
  endtask : t_pdn
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_refresh();
    t_irq();
    t_init();
    t_self();
    t_pdn();
    end_sim();
  end
endmodule : test_sdlp_core
